// >>> src/prioritized_interrupt_controller.sv
// Interrupt controller with pending latches, enables, factor selection and vector supply.
`timescale 1ns/1ps
`default_nettype none

module prioritized_interrupt_controller (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	// Special-function register port.
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata_r,
	// Request pulses from peripherals and the CPU.
	input wire logic software_req,
	input wire logic undefined_op_req,
	input wire logic address_trap_req,
	input wire logic watchdog_req,
	input wire logic external0_req,
	input wire logic external1_req,
	input wire logic time_base_req,
	input wire logic external2_req,
	input wire logic timer1_req,
	input wire logic uart_receive_req,
	input wire logic serial0_req,
	input wire logic uart_transmit_req,
	input wire logic serial1_req,
	input wire logic timer4_req,
	input wire logic timer6_req,
	input wire logic adc_req,
	input wire logic external3_req,
	input wire logic timer3_req,
	input wire logic external5_req,
	input wire logic timer5_req,
	// CPU core side.
	input wire logic instr_boundary,
	input wire logic return_strobe,
	input wire logic return_master_flag,
	output logic irq_request_r,
	output logic [15:0] irq_vector_r,
	output logic accept_busy_r,
	output logic pc_load_r,
	output logic stacked_master_flag_r,
	output logic master_enable_flag_r
);

	// Register state.
	logic [15:0] enable_register_r;
	logic [15:0] enable_register_nxt;
	logic [15:0] pending_latch_r;
	logic [15:0] pending_latch_nxt;
	logic [7:0] factor_selector_r;
	logic [7:0] factor_selector_nxt;
	logic [3:0] accept_count_r;
	logic [3:0] accept_count_nxt;

	// Address decode.
	wire logic wr_enable_low = sfr_wr && (sfr_addr == intc_pkg::ADDR_ENABLE_LOW);
	wire logic wr_enable_high = sfr_wr && (sfr_addr == intc_pkg::ADDR_ENABLE_HIGH);
	wire logic wr_pending_low = sfr_wr && (sfr_addr == intc_pkg::ADDR_PENDING_LOW);
	wire logic wr_pending_high = sfr_wr && (sfr_addr == intc_pkg::ADDR_PENDING_HIGH);
	wire logic wr_selector = sfr_wr && (sfr_addr == intc_pkg::ADDR_FACTOR_SELECTOR);

	// Selector fields; a zero picks the first factor of each pair.
	wire logic rx_pair_select = factor_selector_r[intc_pkg::RX_PAIR_SELECT_BIT];
	wire logic tx_pair_select = factor_selector_r[intc_pkg::TX_PAIR_SELECT_BIT];
	wire logic ext3_pair_select = factor_selector_r[intc_pkg::EXT3_PAIR_SELECT_BIT];
	wire logic ext5_pair_select = factor_selector_r[intc_pkg::EXT5_PAIR_SELECT_BIT];

	// Shared sources: the selector steers one factor of each pair onto the source. The
	// unselected factor never reaches its latch, so a request it raises is simply lost
	// rather than held back; software has to set the selector before such factors run.
	wire logic rx_source_req =
		rx_pair_select ? serial0_req : uart_receive_req;
	wire logic tx_source_req =
		tx_pair_select ? serial1_req : uart_transmit_req;
	wire logic ext3_source_req =
		ext3_pair_select ? timer3_req : external3_req;
	wire logic ext5_source_req =
		ext5_pair_select ? timer5_req : external5_req;

	// Request vector by source number, the strongest source at bit zero.
	wire logic [15:0] source_req = {
		ext5_source_req,
		ext3_source_req,
		adc_req,
		timer6_req,
		timer4_req,
		tx_source_req,
		rx_source_req,
		timer1_req,
		external2_req,
		time_base_req,
		external1_req,
		external0_req,
		watchdog_req,
		address_trap_req,
		undefined_op_req,
		1'b0
	};

	// Acceptance control. A boundary that falls inside an acceptance is not a real
	// instruction end, so it is ignored.
	wire logic idle_boundary = instr_boundary && !accept_busy_r;
	wire logic master_flag = enable_register_r[intc_pkg::MASTER_FLAG_BIT];

	// Candidates: software and latched non-maskable sources regardless of enables,
	// maskable ones only with their own enable and the master flag.
	wire logic [15:0] maskable_ok = pending_latch_r & enable_register_r &
		{16{master_flag}};
	wire logic [15:0] candidates = {
		maskable_ok[15:intc_pkg::FIRST_MASKABLE],
		pending_latch_r[intc_pkg::SRC_WATCHDOG:intc_pkg::FIRST_LATCH],
		software_req
	};

	logic pick_found;
	logic [3:0] pick_index;

	// The picker resolves fixed priority; ties among non-maskable sources go to the
	// lowest number, which is an arbitrary but stable order.
	source_picker u_picker (
		.candidates(candidates),
		.found(pick_found),
		.index(pick_index)
	);

	wire logic accept_start = idle_boundary && pick_found;

	// Vector falls by two per source; software shares the undefined-op entry, which the
	// core tells apart by the instruction it was executing.
	wire logic [15:0] pick_offset = 16'(16'(intc_pkg::VECTOR_STEP) * {12'h000, pick_index});
	wire logic pick_is_software = (pick_index == 4'(intc_pkg::SRC_SOFTWARE));
	wire logic [15:0] pick_vector = pick_is_software ? intc_pkg::SOFTWARE_VECTOR :
		16'(intc_pkg::VECTOR_TOP - pick_offset);

	// Write data widened to the 16-bit views of the paired registers.
	wire logic [15:0] wdata_wide = {sfr_wdata, sfr_wdata};
	wire logic [15:0] wr_lane_pending = {{8{wr_pending_high}}, {8{wr_pending_low}}};
	wire logic [15:0] wr_lane_enable = {{8{wr_enable_high}}, {8{wr_enable_low}}};

	// One latch per source except software. A request in the same cycle as a clear wins, because the
	// write may come from a load that software issued without seeing the new event.
	genvar n;
	generate
		for (n = 0; n < intc_pkg::NUM_SOURCES; n++) begin : g_latch
			if (intc_pkg::LATCH_MASK[n]) begin : g_present
				wire logic sw_clear = wr_lane_pending[n] && !wdata_wide[n] &&
					intc_pkg::CLEARABLE_MASK[n];
				wire logic hw_clear = accept_start && (pick_index == 4'(n));
				assign pending_latch_nxt[n] = source_req[n] ||
					(pending_latch_r[n] && !sw_clear && !hw_clear);
			end else begin : g_absent
				assign pending_latch_nxt[n] = 1'h0;
			end
		end
	endgenerate

	// Enable register: software writes are full read-write on the implemented bits;
	// return restores the stacked master flag, acceptance clears it and beats a write.
	wire logic [15:0] enable_written = (enable_register_r & ~wr_lane_enable) |
		(wdata_wide & wr_lane_enable & intc_pkg::ENABLE_MASK);

	// Master flag priority: acceptance clear, then return restore, then software write.
	always_comb begin
		enable_register_nxt = enable_written;
		if (return_strobe) begin
			enable_register_nxt[intc_pkg::MASTER_FLAG_BIT] = return_master_flag;
		end
		if (accept_start) begin
			enable_register_nxt[intc_pkg::MASTER_FLAG_BIT] = 1'h0;
		end
	end

	// Selector keeps only its four pair bits.
	assign factor_selector_nxt = wr_selector ? (sfr_wdata & intc_pkg::SELECTOR_MASK) :
		factor_selector_r;

	// Read mux; unmapped addresses and missing bits read as zero.
	wire logic [7:0] read_mux =
		(sfr_addr == intc_pkg::ADDR_ENABLE_LOW) ? enable_register_r[7:0] :
		(sfr_addr == intc_pkg::ADDR_ENABLE_HIGH) ? enable_register_r[15:8] :
		(sfr_addr == intc_pkg::ADDR_PENDING_LOW) ? pending_latch_r[7:0] :
		(sfr_addr == intc_pkg::ADDR_PENDING_HIGH) ? pending_latch_r[15:8] :
		(sfr_addr == intc_pkg::ADDR_FACTOR_SELECTOR) ? factor_selector_r :
		intc_pkg::READ_ZERO;

	// Enable register; the mirror output below follows the same next value.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			enable_register_r <= intc_pkg::ENABLE_RESET;
		end else if (clk_en) begin
			enable_register_r <= enable_register_nxt;
		end
	end

	// Pending latches. A request that arrives while the clock enable is low is lost,
	// like any other input in a frozen cycle.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pending_latch_r <= intc_pkg::LATCH_RESET;
		end else if (clk_en) begin
			pending_latch_r <= pending_latch_nxt;
		end
	end

	// Factor selector. Changing it while a shared factor is active may drop one request,
	// which is why software sets it before the factors run.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			factor_selector_r <= intc_pkg::SELECTOR_RESET;
		end else if (clk_en) begin
			factor_selector_r <= factor_selector_nxt;
		end
	end

	// Read data is registered and held until the next read, so a slow core may take it late.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sfr_rdata_r <= intc_pkg::READ_ZERO;
		end else if (clk_en && sfr_rd) begin
			sfr_rdata_r <= read_mux;
		end
	end

	// Boundary sampling: request and vector refresh at every idle boundary, so a boundary
	// without any candidate withdraws the request.
	wire logic sample_now = clk_en && idle_boundary;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_request_r <= 1'h0;
		end else if (sample_now) begin
			irq_request_r <= pick_found;
		end
	end

	// The vector stands until the next idle boundary, covering the whole acceptance.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_vector_r <= intc_pkg::VECTOR_TOP;
		end else if (sample_now) begin
			irq_vector_r <= pick_vector;
		end
	end

	// The flag value before acceptance is what the core pushes with the status word.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stacked_master_flag_r <= 1'h0;
		end else if (sample_now && pick_found) begin
			stacked_master_flag_r <= master_flag;
		end
	end

	// Acceptance sequence: boundaries are ignored while it runs, since the CPU is not
	// executing instructions; the vector is handed over in the cycle after the last machine cycle.
	wire logic count_done = (accept_count_r == intc_pkg::COUNT_ZERO);
	wire logic accept_finish = accept_busy_r && count_done;
	assign accept_count_nxt = accept_start ? intc_pkg::ACCEPT_LAST :
		(accept_busy_r && !count_done) ? 4'(accept_count_r - 4'h1) : accept_count_r;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			accept_count_r <= intc_pkg::COUNT_ZERO;
		end else if (clk_en) begin
			accept_count_r <= accept_count_nxt;
		end
	end

	// Busy covers the eight machine cycles of acceptance.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			accept_busy_r <= 1'h0;
		end else if (clk_en) begin
			if (accept_start) begin
				accept_busy_r <= 1'h1;
			end else if (accept_finish) begin
				accept_busy_r <= 1'h0;
			end
		end
	end

	// One-cycle strobe telling the core to load the vector into its program counter.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pc_load_r <= 1'h0;
		end else if (clk_en) begin
			pc_load_r <= accept_finish;
		end
	end

	// Mirror of the master flag for the CPU status word.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			master_enable_flag_r <= 1'h0;
		end else if (clk_en) begin
			master_enable_flag_r <= enable_register_nxt[intc_pkg::MASTER_FLAG_BIT];
		end
	end

endmodule // prioritized_interrupt_controller

`default_nettype wire

// >>> src/intc_pkg.sv
// Package with the address map, field positions, reset values and timing of the interrupt controller.
package intc_pkg;

	// Register addresses in the special-function area.
	localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
	localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
	localparam logic [7:0] ADDR_PENDING_LOW = 8'h3C;
	localparam logic [7:0] ADDR_PENDING_HIGH = 8'h3D;
	localparam logic [7:0] ADDR_FACTOR_SELECTOR = 8'h3E;

	// Source count and the index ranges of the two kinds of source.
	localparam int NUM_SOURCES = 16;
	localparam int SRC_SOFTWARE = 0;
	localparam int SRC_UNDEFINED = 1;
	localparam int SRC_ADDR_TRAP = 2;
	localparam int SRC_WATCHDOG = 3;
	localparam int FIRST_LATCH = 1;
	localparam int FIRST_MASKABLE = 4;
	localparam int SRC_RX_PAIR = 9;
	localparam int SRC_TX_PAIR = 10;
	localparam int SRC_EXT3_PAIR = 14;
	localparam int SRC_EXT5_PAIR = 15;

	// Bit position of the master enable flag in the 16-bit enable register.
	localparam int MASTER_FLAG_BIT = 0;

	// Bit positions inside the factor selector.
	localparam int RX_PAIR_SELECT_BIT = 6;
	localparam int TX_PAIR_SELECT_BIT = 5;
	localparam int EXT3_PAIR_SELECT_BIT = 1;
	localparam int EXT5_PAIR_SELECT_BIT = 0;

	// Writable and readable bits of each register.
	localparam logic [15:0] ENABLE_MASK = 16'hFFF1;
	localparam logic [15:0] LATCH_MASK = 16'hFFFE;
	localparam logic [15:0] CLEARABLE_MASK = 16'hFFF2;
	localparam logic [7:0] SELECTOR_MASK = 8'h63;

	// Reset values.
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [15:0] LATCH_RESET = 16'h0000;
	localparam logic [7:0] SELECTOR_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Vector table: top entry, spacing between sources, and the software entry.
	localparam logic [15:0] VECTOR_TOP = 16'hFFFE;
	localparam int VECTOR_STEP = 2;
	localparam logic [15:0] SOFTWARE_VECTOR = 16'hFFFC;

	// Acceptance sequence length in machine cycles, one machine cycle per enabled clock.
	localparam int ACCEPT_MACHINE_CYCLES = 8;
	localparam int ACCEPT_COUNT = ACCEPT_MACHINE_CYCLES;
	localparam logic [3:0] ACCEPT_LAST = 4'(ACCEPT_COUNT - 1);
	localparam logic [3:0] COUNT_ZERO = 4'h0;

endpackage

// >>> src/source_picker.sv
// Fixed-priority picker that returns the lowest-numbered candidate source.
`timescale 1ns/1ps
`default_nettype none

module source_picker (
	input wire logic [15:0] candidates,
	output logic found,
	output logic [3:0] index
);

	// Scanning downward lets the lowest index overwrite all others, so index 0 is the
	// strongest; non-maskable sources sit below the maskable ones and therefore win.
	always_comb begin
		found = 1'h0;
		index = 4'h0;
		for (int i = intc_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
			if (candidates[i]) begin
				found = 1'h1;
				index = 4'(i);
			end
		end
	end

endmodule // source_picker

`default_nettype wire

// >>> verif/intc_checker_sva.sv
// Assertion checker for the interrupt controller, bound to its top-level ports.
`timescale 1ns/1ps
`default_nettype none
module intc_checker (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata_r,
	input wire logic instr_boundary,
	input wire logic return_strobe,
	input wire logic return_master_flag,
	input wire logic irq_request_r,
	input wire logic [15:0] irq_vector_r,
	input wire logic accept_busy_r,
	input wire logic pc_load_r,
	input wire logic stacked_master_flag_r,
	input wire logic master_enable_flag_r
);
	// One domain; the acceptance counts assume clk_en stays high, which the bench keeps through every acceptance.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_busy_len;
		$rose(accept_busy_r) |-> accept_busy_r[*8] ##1 (!accept_busy_r && pc_load_r);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("acceptance length wrong");
	property p_stack;
		$rose(accept_busy_r) |-> !master_enable_flag_r &&
			stacked_master_flag_r == $past(master_enable_flag_r);
	endproperty
	a_stack: assert property (p_stack) else $error("master flag not stacked");
	property p_restore;
		return_strobe && clk_en && !instr_boundary |=>
			master_enable_flag_r == $past(return_master_flag);
	endproperty
	a_restore: assert property (p_restore) else $error("master flag not restored");
	property p_gate;
		$rose(accept_busy_r) && irq_vector_r < 16'hFFF8 |-> stacked_master_flag_r;
	endproperty
	a_gate: assert property (p_gate) else $error("maskable taken while masked");
	property p_origin; $rose(accept_busy_r) |-> $past(instr_boundary) && irq_request_r; endproperty
	a_origin: assert property (p_origin) else $error("acceptance without boundary");
	property p_vector; irq_request_r |-> !irq_vector_r[0] && irq_vector_r >= 16'hFFE0; endproperty
	a_vector: assert property (p_vector) else $error("vector out of table");
	property p_pc; pc_load_r |=> !pc_load_r; endproperty
	a_pc: assert property (p_pc) else $error("pc load longer than one cycle");
	property p_rdata; !(sfr_rd && clk_en) |=> $stable(sfr_rdata_r); endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule // intc_checker
bind prioritized_interrupt_controller intc_checker u_intc_checker (.clk_sys, .srst, .clk_en,
	.sfr_rd, .sfr_rdata_r, .instr_boundary, .return_strobe, .return_master_flag, .irq_request_r,
	.irq_vector_r, .accept_busy_r, .pc_load_r, .stacked_master_flag_r, .master_enable_flag_r);
`default_nettype wire

// >>> verif/cpu_core_model.sv
// Behavioural CPU core: marks instruction ends and returns from each serviced interrupt.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
	input wire logic clk_sys,
	input wire logic pc_load_r,
	input wire logic stacked_master_flag_r,
	output logic instr_boundary,
	output logic return_strobe,
	output logic return_master_flag
);
	// Quiet until the bench asks for a boundary.
	initial begin
		instr_boundary = 1'h0;
		return_strobe = 1'h0;
		return_master_flag = 1'h0;
	end
	// One pulse marks the last cycle of an instruction, when requests are sampled.
	task automatic boundary();
		@(negedge clk_sys) instr_boundary = 1'h1;
		@(negedge clk_sys) instr_boundary = 1'h0;
	endtask
	// Handlers are empty, so the return follows the PC load; idle data toggles to stay meaningless.
	always @(negedge clk_sys) begin
		return_strobe <= pc_load_r;
		return_master_flag <= pc_load_r ? stacked_master_flag_r : ~return_master_flag;
	end
endmodule // cpu_core_model
`default_nettype wire

// >>> verif/prioritized_interrupt_controller_test.sv
// Self-checking bench for the interrupt controller with a behavioural CPU core beside it.
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_test;
	logic clk_sys, srst, clk_en, sfr_wr, sfr_rd;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r;
	logic [19:0] req;
	logic [15:0] irq_vector_r;
	logic instr_boundary, return_strobe, return_master_flag, irq_request_r, accept_busy_r;
	logic stacked_master_flag_r, master_enable_flag_r, pc_load_r;
	int err_total = 0, samples_checked = 0, cycles = 0;
	prioritized_interrupt_controller u_prioritized_interrupt_controller (
		.clk_sys, .srst, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_r,
		.software_req(req[0]), .undefined_op_req(req[1]), .address_trap_req(req[2]),
		.watchdog_req(req[3]), .external0_req(req[4]), .external1_req(req[5]),
		.time_base_req(req[6]), .external2_req(req[7]), .timer1_req(req[8]),
		.uart_receive_req(req[9]), .serial0_req(req[10]), .uart_transmit_req(req[11]),
		.serial1_req(req[12]), .timer4_req(req[13]), .timer6_req(req[14]), .adc_req(req[15]),
		.external3_req(req[16]), .timer3_req(req[17]), .external5_req(req[18]),
		.timer5_req(req[19]), .instr_boundary, .return_strobe, .return_master_flag,
		.irq_request_r, .irq_vector_r, .accept_busy_r, .pc_load_r, .stacked_master_flag_r,
		.master_enable_flag_r);
	cpu_core_model u_cpu_core_model (.clk_sys, .pc_load_r, .stacked_master_flag_r,
		.instr_boundary, .return_strobe, .return_master_flag);
	// Free-running 250 MHz clock.
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	// A hung handshake would otherwise stall the run forever.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Register accesses hold the strobe over exactly one sampling edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'h1};
		@(negedge clk_sys) sfr_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys) {sfr_addr, sfr_rd} = {a, 1'h1};
		@(negedge clk_sys) sfr_rd = 1'h0;
		chk("sfr_rdata_r", {8'h00, e}, {8'h00, sfr_rdata_r});
	endtask
	task automatic pulse(input int i);
		@(negedge clk_sys) req[i] = 1'h1;
		@(negedge clk_sys) req[i] = 1'h0;
	endtask
	// Acceptance: vector at once, the PC load eight cycles later, then the model returns.
	task automatic acc(input logic [15:0] v, input logic flag);
		u_cpu_core_model.boundary();
		chk("irq_vector_r", v, irq_vector_r);
		chk("request busy", 16'h0003, {14'h0, irq_request_r, accept_busy_r});
		chk("stacked_master_flag_r", {15'h0, flag}, {15'h0, stacked_master_flag_r});
		chk("master flag", 16'h0, {15'h0, master_enable_flag_r});
		repeat (8) @(negedge clk_sys);
		chk("pc_load busy", 16'h0002, {14'h0, pc_load_r, accept_busy_r});
		@(negedge clk_sys);
	endtask
	task automatic noacc();
		u_cpu_core_model.boundary();
		chk("irq_request_r", 16'h0, {15'h0, irq_request_r});
	endtask
	// Latches set on requests, clear on written zeros only, and freeze with clk_en low.
	task automatic s_latch();
		for (int a = 8'h3A; a < 8'h40; a++)
			rd(8'(a), 8'h00);
		pulse(6);
		pulse(1);
		rd(8'h3C, 8'h42);
		wr(8'h3C, 8'hFD);
		rd(8'h3C, 8'h40);
		wr(8'h3C, 8'h00);
		clk_en = 1'h0;
		pulse(7);
		clk_en = 1'h1;
		rd(8'h3C, 8'h00);
	endtask
	// Each shared source latches only its selected factor; the other request is lost.
	task automatic s_select();
		int fa[4] = '{9, 11, 16, 18};
		int lb[4] = '{9, 10, 14, 15};
		int sb[4] = '{6, 5, 1, 0};
		for (int i = 0; i < 4; i++) begin
			for (int s = 0; s < 2; s++) begin
				wr(8'h3E, 8'(s << sb[i]));
				pulse(fa[i] + 1 - s);
				rd(8'h3D, 8'h00);
				pulse(fa[i] + s);
				rd(8'h3D, 8'(1 << (lb[i] - 8)));
				wr(8'h3D, 8'h00);
			end
		end
		wr(8'h3E, 8'hFF);
		rd(8'h3E, 8'h63);
		wr(8'h3E, 8'h00);
	endtask
	// Maskable sources need latch, own enable and master flag; the lower number wins.
	task automatic s_accept();
		wr(8'h3B, 8'hFF);
		rd(8'h3B, 8'hFF);
		wr(8'h3B, 8'h00);
		wr(8'h3A, 8'h6E);
		rd(8'h3A, 8'h60);
		pulse(6);
		pulse(5);
		noacc();
		wr(8'h3A, 8'h61);
		acc(16'hFFF4, 1'h1);
		rd(8'h3C, 8'h40);
		rd(8'h3A, 8'h61);
		acc(16'hFFF2, 1'h1);
		pulse(6);
		wr(8'h3A, 8'h00);
		wr(8'h3A, 8'h20);
		wr(8'h3A, 8'h21);
		noacc();
		wr(8'h3A, 8'h00);
		wr(8'h3C, 8'h00);
	endtask
	// Non-maskable sources are taken with the master flag clear, lowest number first.
	task automatic s_nmi();
		// The watchdog here is taken to route its output to an interrupt, not to reset.
		pulse(3);
		pulse(2);
		acc(16'hFFFA, 1'h0);
		rd(8'h3C, 8'h08);
		acc(16'hFFF8, 1'h0);
		@(negedge clk_sys) req[0] = 1'h1;
		acc(16'hFFFC, 1'h0);
		req[0] = 1'h0;
		noacc();
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Reset for twelve cycles, then the scenarios in turn.
	initial begin
		{srst, clk_en, sfr_wr, sfr_rd} = 4'hC;
		{sfr_addr, sfr_wdata, req} = '0;
		repeat (12) @(negedge clk_sys);
		srst = 1'h0;
		s_latch();
		s_select();
		s_accept();
		s_nmi();
		summarize();
	end
endmodule // prioritized_interrupt_controller_test
`default_nettype wire
